// ---- dac_filter_control_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Common mode applies the left attenuation code to both channels.
// - Independent mode takes left and right codes from their own fields.
// - Right code gives gain of half dB times code minus 255.
// - Code all ones is unity gain; one below is half dB down.
// - Code zero silences the channel; code one is 127 dB down.
// - Right load updates right level and refreshes left with latest left code.
// - In independent mode, without right load, right output level keeps its applied value.
// - Soft mute bit low mutes both channels, high releases them.
// - De-emphasis bit low disables, high enables de-emphasis.
// - Non-I2S input codes select 16/20/24 standard or 24 left-justified.
// - I2S input codes 00/01 select 16/24 bit; others reserved for host.
// - Output word code selects 16, 18, 20 or 24 bit words.
// - I2S select bit chooses standard/left-justified or I2S input.
// - Polarity bit zero means high is left; one means low is left.
// - Roll-off bit selects sharp at zero, slow at one.
// - Clock divide bit gives crystal rate at zero, half at one.
// - Rate code 00 44.1k, 10 48k, 11 32k; 01 reserved.
// - Control words are 16 bits, most significant bit first.
// - Bits 10 and 9 carry the target register address.
module dac_filter_control_regs (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic I_CTRL_LATCH,
  input wire logic I_CTRL_CLK,
  input wire logic I_CTRL_DATA,
  input wire logic I_SAMPLE_STROBE,
  input wire logic I_INPUT_CHAN_CLOCK,
  output logic [7:0] O_LEFT_LEVEL,
  output logic [7:0] O_RIGHT_LEVEL,
  output logic [7:0] O_LEFT_ATTEN_STEPS,
  output logic [7:0] O_RIGHT_ATTEN_STEPS,
  output logic O_LEFT_SILENT,
  output logic O_RIGHT_SILENT,
  output logic O_SOFT_MUTE,
  output logic O_DEEMPH_ENABLE,
  output logic [1:0] O_DEEMPH_RATE_SEL,
  output dac_filter_ctrl_pkg::in_fmt_t O_INPUT_FORMAT,
  output logic [4:0] O_INPUT_WORD_LEN,
  output logic [4:0] O_OUTPUT_WORD_LEN,
  output logic O_CHAN_IS_LEFT,
  output logic O_SLOW_ROLLOFF,
  output logic O_CLKOUT_DIV2
);
  import dac_filter_ctrl_pkg::*;

  logic ctrl_clk_q;
  logic ctrl_latch_q;
  logic [15:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic word_valid;
  logic [1:0] word_addr;
  logic [7:0] left_code_q;
  logic [7:0] pend_left_q;
  logic [7:0] pend_right_q;
  logic mute_n_q;
  logic deemph_q;
  logic [1:0] iw_q;
  logic [1:0] ow_q;
  logic i2s_q;
  logic pol_q;
  logic common_q;
  logic rolloff_q;
  logic clkdiv_q;
  logic [1:0] sf_q;
  logic [7:0] left_next;
  logic [7:0] right_next;

  // Edge history of the serial clock and latch; pins are already synchronous
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      ctrl_clk_q <= 1'b0;
      ctrl_latch_q <= 1'b0;
    end else begin
      ctrl_clk_q <= I_CTRL_CLK;
      ctrl_latch_q <= I_CTRL_LATCH;
    end
  end

  // Shift in on each serial clock rise, first bit ends up in bit 15
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      shift_q <= 16'h0000;
    end else if (I_CTRL_CLK && !ctrl_clk_q) begin
      shift_q <= {shift_q[14:0], I_CTRL_DATA};
    end
  end

  // Bit count saturates so a long burst still keeps the last sixteen bits
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      bit_cnt_q <= 5'h00;
    end else if (I_CTRL_LATCH && !ctrl_latch_q) begin
      bit_cnt_q <= 5'h00;
    end else if (I_CTRL_CLK && !ctrl_clk_q && bit_cnt_q != WORD_BITS_CNT) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // A short word is dropped rather than half-applied
  assign word_valid = I_CTRL_LATCH && !ctrl_latch_q && bit_cnt_q == WORD_BITS_CNT;
  assign word_addr = shift_q[ADDR_HI:ADDR_LO];

  // Left code store; its own load bit also stages the left level
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      left_code_q <= ATTEN_UNITY;
    end else if (word_valid && word_addr == ADDR_LEFT_ATTEN) begin
      left_code_q <= shift_q[CODE_HI:CODE_LO];
    end
  end

  // Staged levels wait here until the next sample boundary
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      pend_left_q <= ATTEN_UNITY;
      pend_right_q <= ATTEN_UNITY;
    end else if (word_valid && shift_q[LOAD_BIT]) begin
      if (word_addr == ADDR_RIGHT_ATTEN) begin
        pend_right_q <= shift_q[CODE_HI:CODE_LO];
        pend_left_q <= left_code_q;
      end else if (word_addr == ADDR_LEFT_ATTEN) begin
        pend_left_q <= shift_q[CODE_HI:CODE_LO];
      end
    end
  end

  // Mute and format register
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      mute_n_q <= 1'b1;
      deemph_q <= 1'b0;
      iw_q <= 2'h0;
      ow_q <= 2'h0;
    end else if (word_valid && word_addr == ADDR_MUTE_FORMAT) begin
      mute_n_q <= shift_q[MUTE_N_BIT];
      deemph_q <= shift_q[DEEMPH_BIT];
      iw_q <= shift_q[IW_HI:IW_LO];
      ow_q <= shift_q[OW_HI:OW_LO];
    end
  end

  // Interface and filter register
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      i2s_q <= 1'b0;
      pol_q <= 1'b0;
      common_q <= 1'b0;
      rolloff_q <= 1'b0;
      clkdiv_q <= 1'b0;
      sf_q <= SF_44K1;
    end else if (word_valid && word_addr == ADDR_IFACE_FILTER) begin
      i2s_q <= shift_q[I2S_BIT];
      pol_q <= shift_q[POL_BIT];
      common_q <= shift_q[COMMON_BIT];
      rolloff_q <= shift_q[ROLLOFF_BIT];
      clkdiv_q <= shift_q[CLKDIV_BIT];
      sf_q <= shift_q[SF_HI:SF_LO];
    end
  end

  // Common mode steers the left code onto both attenuators
  assign left_next = pend_left_q;
  assign right_next = common_q ? pend_left_q : pend_right_q;

  // Gains change only on the sample strobe, so no sample sees a torn value
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_LEFT_LEVEL <= ATTEN_UNITY;
      O_RIGHT_LEVEL <= ATTEN_UNITY;
      O_LEFT_ATTEN_STEPS <= 8'h00;
      O_RIGHT_ATTEN_STEPS <= 8'h00;
      O_LEFT_SILENT <= 1'b0;
      O_RIGHT_SILENT <= 1'b0;
      O_SOFT_MUTE <= 1'b0;
    end else if (I_SAMPLE_STROBE) begin
      O_LEFT_LEVEL <= left_next;
      O_RIGHT_LEVEL <= right_next;
      O_LEFT_ATTEN_STEPS <= ATTEN_UNITY - left_next;
      O_RIGHT_ATTEN_STEPS <= ATTEN_UNITY - right_next;
      O_LEFT_SILENT <= left_next == ATTEN_SILENT;
      O_RIGHT_SILENT <= right_next == ATTEN_SILENT;
      O_SOFT_MUTE <= !mute_n_q;
    end
  end

  // Static selections; a reserved rate or input code keeps the last good one
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_DEEMPH_ENABLE <= 1'b0;
      O_DEEMPH_RATE_SEL <= SF_44K1;
      O_OUTPUT_WORD_LEN <= LEN_16;
      O_CHAN_IS_LEFT <= 1'b0;
      O_SLOW_ROLLOFF <= 1'b0;
      O_CLKOUT_DIV2 <= 1'b0;
    end else begin
      O_DEEMPH_ENABLE <= deemph_q;
      if (sf_q != SF_RESERVED) begin
        O_DEEMPH_RATE_SEL <= sf_q;
      end
      unique case (ow_q)
        2'h0: O_OUTPUT_WORD_LEN <= LEN_16;
        2'h1: O_OUTPUT_WORD_LEN <= LEN_18;
        2'h2: O_OUTPUT_WORD_LEN <= LEN_20;
        2'h3: O_OUTPUT_WORD_LEN <= LEN_24;
      endcase
      O_CHAN_IS_LEFT <= I_INPUT_CHAN_CLOCK ^ pol_q;
      O_SLOW_ROLLOFF <= rolloff_q;
      O_CLKOUT_DIV2 <= clkdiv_q;
    end
  end

  // Input format decode from the two registers together
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_INPUT_FORMAT <= FMT_STANDARD;
      O_INPUT_WORD_LEN <= LEN_16;
    end else if (!i2s_q) begin
      O_INPUT_FORMAT <= (iw_q == 2'h3) ? FMT_LEFT_JUST : FMT_STANDARD;
      unique case (iw_q)
        2'h0: O_INPUT_WORD_LEN <= LEN_16;
        2'h1: O_INPUT_WORD_LEN <= LEN_20;
        2'h2: O_INPUT_WORD_LEN <= LEN_24;
        2'h3: O_INPUT_WORD_LEN <= LEN_24;
      endcase
    end else if (!iw_q[1]) begin
      O_INPUT_FORMAT <= FMT_I2S;
      O_INPUT_WORD_LEN <= iw_q[0] ? LEN_24 : LEN_16;
    end
  end

  // Checks
  sequence s_right_load;
    word_valid && word_addr == ADDR_RIGHT_ATTEN && shift_q[LOAD_BIT];
  endsequence

  sequence s_strobe_indep;
    I_SAMPLE_STROBE && !common_q;
  endsequence

  a_common_atten: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_SAMPLE_STROBE && common_q |=> O_RIGHT_LEVEL == O_LEFT_LEVEL)
    else $error("Common mode right level differs from left");

  a_right_stage: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    s_right_load |=> pend_right_q == $past(shift_q[CODE_HI:CODE_LO]) &&
      pend_left_q == $past(left_code_q))
    else $error("Right load did not stage both levels");

  a_right_apply: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    s_strobe_indep |=> O_RIGHT_LEVEL == $past(pend_right_q))
    else $error("Staged right level not applied at strobe");

  a_level_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    !I_SAMPLE_STROBE |=> $stable(O_RIGHT_LEVEL) && $stable(O_LEFT_LEVEL) &&
      $stable(O_SOFT_MUTE))
    else $error("Level changed off a sample boundary");

  a_atten_steps: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    O_RIGHT_ATTEN_STEPS == ATTEN_UNITY - O_RIGHT_LEVEL)
    else $error("Right attenuation steps wrong");

  a_silent_code: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    O_RIGHT_SILENT == (O_RIGHT_LEVEL == ATTEN_SILENT))
    else $error("Silent flag does not match zero code");

  a_mute_polarity: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_SAMPLE_STROBE |=> O_SOFT_MUTE == !$past(mute_n_q))
    else $error("Soft mute polarity wrong");

  a_short_word: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    I_CTRL_LATCH && !ctrl_latch_q && bit_cnt_q != WORD_BITS_CNT |=>
      $stable(mute_n_q) && $stable(sf_q) && $stable(left_code_q))
    else $error("Short word changed a register");

  a_i2s_len: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    i2s_q && iw_q == 2'h1 ##1 $stable(iw_q) && $stable(i2s_q) |->
      O_INPUT_FORMAT == FMT_I2S && O_INPUT_WORD_LEN == LEN_24)
    else $error("I2S 24 bit decode wrong");

  a_chan_pol: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    !pol_q |=> O_CHAN_IS_LEFT == $past(I_INPUT_CHAN_CLOCK))
    else $error("Channel clock polarity wrong");

  // A right word without its load bit must leave the staged right level alone
  a_right_keep: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    word_valid && word_addr == ADDR_RIGHT_ATTEN && !shift_q[LOAD_BIT] |=>
      $stable(pend_right_q))
    else $error("Right level staged without its load bit");

  a_rate_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    sf_q == SF_RESERVED |=> $stable(O_DEEMPH_RATE_SEL))
    else $error("Reserved rate code reached the rate output");

  a_out_len: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    ow_q == 2'h3 |=> O_OUTPUT_WORD_LEN == LEN_24)
    else $error("Output word code three not decoded as 24 bits");

  a_left_silent: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    O_LEFT_SILENT == (O_LEFT_LEVEL == ATTEN_SILENT))
    else $error("Left silent flag does not match zero code");

endmodule

// ---- dac_filter_ctrl_pkg.sv ----
package dac_filter_ctrl_pkg;

  // Control word shape
  localparam int WORD_BITS = 16;
  localparam logic [4:0] WORD_BITS_CNT = 5'h10;

  // Register address field and addresses
  localparam int ADDR_HI = 10;
  localparam int ADDR_LO = 9;
  localparam logic [1:0] ADDR_LEFT_ATTEN = 2'h0;
  localparam logic [1:0] ADDR_RIGHT_ATTEN = 2'h1;
  localparam logic [1:0] ADDR_MUTE_FORMAT = 2'h2;
  localparam logic [1:0] ADDR_IFACE_FILTER = 2'h3;

  // Attenuation register fields
  localparam int LOAD_BIT = 8;
  localparam int CODE_HI = 7;
  localparam int CODE_LO = 0;

  // Mute and format register fields
  localparam int MUTE_N_BIT = 0;
  localparam int DEEMPH_BIT = 1;
  localparam int IW_HI = 4;
  localparam int IW_LO = 3;
  localparam int OW_HI = 6;
  localparam int OW_LO = 5;

  // Interface and filter register fields
  localparam int I2S_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int COMMON_BIT = 2;
  localparam int ROLLOFF_BIT = 3;
  localparam int CLKDIV_BIT = 5;
  localparam int SF_HI = 7;
  localparam int SF_LO = 6;

  // Attenuation codes
  localparam logic [7:0] ATTEN_UNITY = 8'hff;
  localparam logic [7:0] ATTEN_SILENT = 8'h00;

  // Word lengths in bits
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_18 = 5'h12;
  localparam logic [4:0] LEN_20 = 5'h14;
  localparam logic [4:0] LEN_24 = 5'h18;

  // De-emphasis rate codes
  localparam logic [1:0] SF_44K1 = 2'h0;
  localparam logic [1:0] SF_RESERVED = 2'h1;
  localparam logic [1:0] SF_48K = 2'h2;
  localparam logic [1:0] SF_32K = 2'h3;

  typedef enum logic [1:0] {FMT_STANDARD, FMT_LEFT_JUST, FMT_I2S} in_fmt_t;

endpackage

// ---- host_ctrl_model.sv ----
`timescale 1ns/1ps
module host_ctrl_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_word,
  input wire logic [4:0] i_nbits,
  output logic o_cclk,
  output logic o_cdata,
  output logic o_latch,
  output logic o_busy
);
  // Host bit-bangs the port; its clock stands low between frames
  initial begin
    o_cclk = 1'b0;
    o_cdata = 1'b0;
    o_latch = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk iff i_go);
      #1 o_busy = 1'b1;
      // Bit 15 goes first; words carry zero in reserved bits
      for (int k = 0; k < i_nbits; k++) begin
        o_cdata = i_word[15 - k];
        o_cclk = 1'b0;
        @(posedge i_clk);
        #1 o_cclk = 1'b1;
        @(posedge i_clk);
        #1;
      end
      o_cclk = 1'b0;
      o_latch = 1'b1; // Address rides in bits 10 and 9
      @(posedge i_clk);
      #1 o_latch = 1'b0;
      o_cdata = ~o_cdata; // Released line shows no stale bit
      o_busy = 1'b0;
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import dac_filter_ctrl_pkg::*;
  logic clk, srst, go, stb, chan, cclk, cdata, latch, busy;
  logic [15:0] word;
  logic [4:0] nb;
  logic [7:0] ll, rl, lst, rst;
  logic lsil, rsil, mute, deemph_enable, slow, div2, isl;
  logic [1:0] rate;
  in_fmt_t fmt;
  logic [4:0] ilen, olen;
  int mismatches, check_count;
  logic [4:0] owl [4] = '{LEN_16, LEN_18, LEN_20, LEN_24};
  logic [4:0] iwl [4] = '{LEN_16, LEN_20, LEN_24, LEN_24};
  logic [1:0] sft [4] = '{SF_44K1, SF_48K, SF_32K, SF_48K};

  host_ctrl_model host_u (.i_clk(clk), .i_go(go), .i_word(word), .i_nbits(nb),
    .o_cclk(cclk), .o_cdata(cdata), .o_latch(latch), .o_busy(busy));

  dac_filter_control_regs dut_u (.I_CLK_SYS(clk), .I_SRST(srst), .I_CTRL_LATCH(latch),
    .I_CTRL_CLK(cclk), .I_CTRL_DATA(cdata), .I_SAMPLE_STROBE(stb),
    .I_INPUT_CHAN_CLOCK(chan), .O_LEFT_LEVEL(ll), .O_RIGHT_LEVEL(rl),
    .O_LEFT_ATTEN_STEPS(lst), .O_RIGHT_ATTEN_STEPS(rst), .O_LEFT_SILENT(lsil),
    .O_RIGHT_SILENT(rsil), .O_SOFT_MUTE(mute), .O_DEEMPH_ENABLE(deemph_enable),
    .O_DEEMPH_RATE_SEL(rate), .O_INPUT_FORMAT(fmt), .O_INPUT_WORD_LEN(ilen),
    .O_OUTPUT_WORD_LEN(olen), .O_CHAN_IS_LEFT(isl), .O_SLOW_ROLLOFF(slow),
    .O_CLKOUT_DIV2(div2));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // One word, then an optional sample boundary so staged levels land
  task automatic wr(input logic [15:0] w, input logic s, input logic [4:0] n = 5'h10);
    @(posedge clk);
    #1 word = w;
    nb = n;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    // Let the host raise busy before polling it
    @(posedge clk);
    for (int t = 0; t < 80 && busy === 1'b1; t++) @(posedge clk);
    chk("host_done", 8'h00, {7'h0, busy});
    repeat (3) @(posedge clk);
    #1 stb = s;
    @(posedge clk);
    #1 stb = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run of some 1500 cycles
  initial begin
    #800000;
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {srst, go, stb, chan, word, nb, mismatches, check_count} = '0;
    srst = 1'b1;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    wr({5'h0, ADDR_IFACE_FILTER, 9'h000}, 1'b0);
    chk("right_level", ATTEN_UNITY, rl);
    // Every output and input word code, mute and de-emphasis both ways
    for (int k = 0; k < 16; k++) begin
      wr({5'h0, ADDR_MUTE_FORMAT, 2'h0, k[3:2], k[1:0], 1'b0, k[0], k[1]}, 1'b1);
      chk("out_len", {3'h0, owl[k[3:2]]}, {3'h0, olen});
      chk("in_len", {3'h0, iwl[k[1:0]]}, {3'h0, ilen});
      chk("in_fmt", (k[1:0] == 2'h3) ? 8'h01 : 8'h00, {6'h0, fmt});
      chk("deemph", {7'h0, k[0]}, {7'h0, deemph_enable});
      chk("mute", {7'h0, ~k[1]}, {7'h0, mute});
    end
    wr({5'h0, ADDR_IFACE_FILTER, 9'h001}, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr({5'h0, ADDR_MUTE_FORMAT, 5'h00, k[0], 3'h1}, 1'b1);
      chk("i2s_fmt", {6'h0, FMT_I2S}, {6'h0, fmt});
      chk("i2s_len", {3'h0, k[0] ? LEN_24 : LEN_16}, {3'h0, ilen});
    end
    // Rates, divider, roll-off and channel polarity at both clock levels
    for (int k = 0; k < 4; k++) begin
      chan = k[1];
      wr({5'h0, ADDR_IFACE_FILTER, 1'b0, sft[k], k[1], 1'b0, k[0] ^ k[1], 1'b0, k[0], 1'b0},
        1'b0);
      chk("rate", {6'h0, sft[k]}, {6'h0, rate});
      chk("div2", {7'h0, k[1]}, {7'h0, div2});
      chk("slow", {7'h0, k[0] ^ k[1]}, {7'h0, slow});
      chk("is_left", {7'h0, k[0] ^ k[1]}, {7'h0, isl});
    end
    // Reserved rate holds the last one; a 15-bit frame that would set roll-off is dropped
    wr({5'h0, ADDR_IFACE_FILTER, 9'h061}, 1'b0);
    chk("rate_hold", {6'h0, SF_48K}, {6'h0, rate});
    wr({4'h0, ADDR_IFACE_FILTER, 9'h008, 1'b0}, 1'b0, 5'h0f);
    chk("short_word", 8'h00, {7'h0, slow});
    // Levels wait for the sample boundary
    wr({5'h0, ADDR_RIGHT_ATTEN, 1'b1, 8'hfe}, 1'b0);
    chk("right_pend", ATTEN_UNITY, rl);
    wr({5'h0, ADDR_LEFT_ATTEN, 9'h000}, 1'b1);
    chk("right_fe", 8'hfe, rl);
    chk("right_steps", 8'h01, rst);
    wr({5'h0, ADDR_RIGHT_ATTEN, 1'b1, 8'h01}, 1'b1);
    chk("left_zero", ATTEN_SILENT, ll);
    chk("left_steps", 8'hff, lst);
    chk("left_silent", 8'h01, {7'h0, lsil});
    chk("right_steps", 8'hfe, rst);
    chk("right_silent", 8'h00, {7'h0, rsil});
    wr({5'h0, ADDR_RIGHT_ATTEN, 1'b0, 8'h80}, 1'b1);
    chk("right_keep", 8'h01, rl);
    // Common mode copies the left code to the right channel
    wr({5'h0, ADDR_LEFT_ATTEN, 9'h040}, 1'b0);
    wr({5'h0, ADDR_IFACE_FILTER, 9'h004}, 1'b0);
    wr({5'h0, ADDR_RIGHT_ATTEN, 1'b1, 8'h33}, 1'b1);
    chk("right_common", 8'h40, rl);
    chk("left_latest", 8'h40, ll);
    wr({5'h0, ADDR_IFACE_FILTER, 9'h000}, 1'b0);
    wr({5'h0, ADDR_RIGHT_ATTEN, 1'b1, 8'h33}, 1'b1);
    chk("right_indep", 8'h33, rl);
    end_of_test();
  end
endmodule
